/* inc/smfs_pkg.sv */
// Package for the supply monitor and start-up block
`default_nettype none
package smfs_pkg;
	// Timing
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned BLANK_US = 2000;
	localparam int unsigned BLANK_CYC = BLANK_US * (CLK_HZ / 1000000);
	localparam int unsigned BLANK_W = 18;
	// Cycles spent in lockout state after release, one per synchroniser stage
	localparam int unsigned SETTLE_CYC = 2;
	// Register byte offsets
	localparam logic [3:0] OFS_GLOBAL = 4'h0;
	localparam logic [3:0] OFS_INTERNAL = 4'h4;
	localparam logic [3:0] OFS_CONFIG = 4'h8;
	localparam logic [3:0] OFS_MASK = 4'hc;
	// Fault bit positions in status and mask
	localparam int unsigned BIT_LINK = 0;
	localparam int unsigned BIT_UV = 1;
	localparam int unsigned BIT_MISS = 2;
	localparam int unsigned BIT_OVC = 3;
	// Reset values
	localparam logic [3:0] FAULT_RST = 4'h7;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [7:0] ADDR_REG_RST = 8'h80;
	// Start-up states
	typedef enum logic [1:0] {
		SMFS_LOCK,
		SMFS_CONFIG,
		SMFS_RUN
	} smfs_state_t;
	// Sampled configuration
	typedef struct packed {
		logic serial_sel;
		logic spi_format1;
		logic spi_format0;
	} smfs_cfg_t;
	// Parallel strobes
	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
		logic ale;
		logic latch_n;
	} smfs_strobe_t;
endpackage
`default_nettype wire

/* rtl/smfs_sync.sv */
// Two flip-flop synchroniser for a bus of pin levels
`default_nettype none
module smfs_sync #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	// Only the second stage is read outside
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			q_o <= '0;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* rtl/smfs_blank.sv */
// Blanking filter: output follows input only after it stood stable
`default_nettype none
module smfs_blank
	import smfs_pkg::*;
#(
	parameter int unsigned CYC = BLANK_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Filtered comparator
	input wire logic raw_i,
	output logic filt_o
);
	logic [BLANK_W-1:0] cnt_q;
	// Restart count whenever the raw level matches the filtered one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			filt_o <= 1'b0;
		end else if (raw_i == filt_o) begin
			cnt_q <= '0;
		end else if (cnt_q >= BLANK_W'(CYC - 1)) begin
			cnt_q <= '0;
			filt_o <= raw_i;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

/* rtl/smfs_top.sv */
// Supply supervision, start-up configuration and fault pin of the driver
// What this block does
// - Hold every register but the pin synchroniser at its reset value during supply lockout.
// - Lockout presets link, undervoltage and missing-supply flags, fault pin low.
// - After lockout release, sample interface-pick and both serial-format pins.
// - Ignore the parallel strobes until configuration has finished.
// - Keep all eight bus lines high impedance until configuration completes.
// - Blank both supply comparators for 2 ms before updating flags.
// - Undervoltage sets the undervoltage flag; operation continues.
// - Missing supply sets the missing-supply flag.
// - At reset level switch power side off; controller side stays alive.
// - Switch a channel off during overcurrent, back on when it clears.
// - Direct mode strobes drive each output straight from its bus line.
// - Interface-pick sampled high selects serial, otherwise parallel.
// - Direct mode starts with address register top bit set for writing.
`default_nettype none
module smfs_top
	import smfs_pkg::*;
#(
	parameter int unsigned BLANK = BLANK_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Classic Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// Supply comparators and lockout (pins)
	input wire logic supply_lockout_i,
	input wire logic uv_cmp_i,
	input wire logic miss_cmp_i,
	input wire logic reset_level_i,
	input wire logic link_fault_i,
	// Configuration pins
	input wire logic sel_pin_i,
	input wire logic spi_format_pin0_i,
	input wire logic spi_format_pin1_i,
	// Parallel strobes and bus lines
	input wire smfs_strobe_t strobe_i,
	input wire logic outputs_off_n_i,
	input wire logic [7:0] bus_lines_i,
	output logic [7:0] bus_lines_o,
	output logic [7:0] bus_lines_oe_o,
	// Channel overcurrent per output
	input wire logic [7:0] overcurrent_i,
	// Outputs and status
	output logic [7:0] drive_outputs_o,
	output logic power_on_o,
	output logic fault_n_o,
	output logic irq_o,
	output smfs_cfg_t cfg_o,
	output logic cfg_done_o
);
	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	// Nine single pins, five strobes, eight bus lines, eight overcurrent inputs
	localparam int unsigned NSYNC = 30;
	logic [NSYNC-1:0] pin_s;
	logic lock_s, uv_s, miss_s, rlev_s, link_s, sel_s, f0_s, f1_s, off_n_s;
	smfs_strobe_t str_s;
	logic [7:0] bus_s, ovc_s;
	smfs_sync #(.W(NSYNC)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({supply_lockout_i, uv_cmp_i, miss_cmp_i, reset_level_i, link_fault_i,
			sel_pin_i, spi_format_pin0_i, spi_format_pin1_i, outputs_off_n_i,
			strobe_i, bus_lines_i, overcurrent_i}),
		.q_o(pin_s)
	);
	assign {lock_s, uv_s, miss_s, rlev_s, link_s, sel_s, f0_s, f1_s, off_n_s,
		str_s, bus_s, ovc_s} = pin_s;

	// Internal reset: system reset or supply lockout
	logic irst;
	assign irst = rst_i | lock_s;

	// ------------------------------------------------------------
	// Start-up sequencing
	// ------------------------------------------------------------
	smfs_state_t state_q;
	smfs_cfg_t cfg_q;
	logic [1:0] settle_q;
	logic settled;

	// Count cycles in lockout state so the pin synchroniser, cleared by
	// reset, carries real pin levels before the selections are caught
	always_ff @(posedge clk_i) begin
		if (irst) begin
			settle_q <= 2'h0;
		end else if (state_q == SMFS_LOCK && !settled) begin
			settle_q <= settle_q + 2'h1;
		end
	end
	assign settled = (settle_q == 2'(SETTLE_CYC - 1));

	// Lockout returns to SMFS_LOCK; one config cycle follows the settle wait
	always_ff @(posedge clk_i) begin
		if (irst) begin
			state_q <= SMFS_LOCK;
		end else begin
			case (state_q)
				SMFS_LOCK: begin
					if (settled) begin
						state_q <= SMFS_CONFIG;
					end
				end
				SMFS_CONFIG: state_q <= SMFS_RUN;
				SMFS_RUN: state_q <= SMFS_RUN;
				default: state_q <= SMFS_LOCK;
			endcase
		end
	end

	// Configuration pins caught once, in the config state
	always_ff @(posedge clk_i) begin
		if (irst) begin
			cfg_q <= '0;
		end else if (state_q == SMFS_CONFIG) begin
			cfg_q <= '{serial_sel: sel_s, spi_format1: f1_s, spi_format0: f0_s};
		end
	end
	assign cfg_o = cfg_q;
	assign cfg_done_o = (state_q == SMFS_RUN);

	// ------------------------------------------------------------
	// Supply blanking filters
	// ------------------------------------------------------------
	logic uv_f, miss_f;
	smfs_blank #(.CYC(BLANK)) u_blank_uv (
		.clk_i(clk_i),
		.rst_i(irst),
		.raw_i(uv_s),
		.filt_o(uv_f)
	);
	smfs_blank #(.CYC(BLANK)) u_blank_miss (
		.clk_i(clk_i),
		.rst_i(irst),
		.raw_i(miss_s),
		.filt_o(miss_f)
	);

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic req, wr_req, rd_global, rd_internal;
	logic [3:0] mask_q;
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr_req = req & wb_we_i & wb_sel_i[0];
	assign rd_global = req & ~wb_we_i & (wb_adr_i == OFS_GLOBAL);
	assign rd_internal = req & ~wb_we_i & (wb_adr_i == OFS_INTERNAL);

	// Decode of the four mapped offsets; anything else is answered with err
	logic mapped;
	always_comb begin
		case (wb_adr_i)
			OFS_GLOBAL, OFS_INTERNAL, OFS_CONFIG, OFS_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Fault flags
	// ------------------------------------------------------------
	logic [3:0] flags_q;
	logic [3:0] events;
	logic [3:0] clr_w1c;
	logic seen_global_q, seen_internal_q, rd_both;
	// Live event levels; each one re-sets its sticky bit every cycle it stands
	assign events = {|ovc_s, miss_f, uv_f, link_s};
	// Writing one to a global fault bit clears it
	assign clr_w1c = (wr_req && wb_adr_i == OFS_GLOBAL) ? wb_dat_i[3:0] : 4'h0;
	// A read of one fault register completes the pair once the other was read;
	// reading the same register twice does not release the fault pin
	assign rd_both = (rd_global & seen_internal_q) | (rd_internal & seen_global_q);

	// Remember a read of the global fault register until the pair completes
	always_ff @(posedge clk_i) begin
		if (irst || rd_both) begin
			seen_global_q <= 1'b0;
		end else if (rd_global) begin
			seen_global_q <= 1'b1;
		end
	end

	// Remember a read of the internal fault register until the pair completes
	always_ff @(posedge clk_i) begin
		if (irst || rd_both) begin
			seen_internal_q <= 1'b0;
		end else if (rd_internal) begin
			seen_internal_q <= 1'b1;
		end
	end

	// Sticky flags; a live event wins over any clear
	always_ff @(posedge clk_i) begin
		if (irst) begin
			flags_q <= FAULT_RST;
		end else begin
			flags_q <= (flags_q & ~clr_w1c & ~{4{rd_both}}) | events;
		end
	end

	// ------------------------------------------------------------
	// Fault pin and interrupt
	// ------------------------------------------------------------
	// fault low while set
	assign fault_n_o = ~(flags_q[BIT_LINK] | flags_q[BIT_UV] | flags_q[BIT_MISS]);
	// Level interrupt: any unmasked sticky bit, overcurrent included
	assign irq_o = |(flags_q & mask_q);

	// Mask register
	always_ff @(posedge clk_i) begin
		if (irst) begin
			mask_q <= MASK_RST;
		end else if (wr_req && wb_adr_i == OFS_MASK) begin
			mask_q <= wb_dat_i[3:0];
		end
	end

	// ------------------------------------------------------------
	// Read path and answer
	// ------------------------------------------------------------
	// Read data chosen from the addressed register
	logic [31:0] rdata;
	always_comb begin
		case (wb_adr_i)
			OFS_GLOBAL: rdata = {28'h0, flags_q};
			OFS_INTERNAL: rdata = {24'h0, ovc_s};
			OFS_CONFIG: rdata = {27'h0, cfg_done_o, rlev_s, cfg_q[2:1], cfg_q[0]};
			OFS_MASK: rdata = {28'h0, mask_q};
			default: rdata = 32'h0;
		endcase
	end

	// Answer one cycle after the request; unmapped answers with err, so a stray
	// address never leaves the master waiting
	always_ff @(posedge clk_i) begin
		if (irst) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			wb_ack_o <= req & mapped;
			wb_err_o <= req & ~mapped;
		end
	end

	// Read data registered with the answer and held until the next read
	always_ff @(posedge clk_i) begin
		if (irst) begin
			wb_dat_o <= 32'h0;
		end else if (req & ~wb_we_i) begin
			wb_dat_o <= rdata;
		end
	end

	// ------------------------------------------------------------
	// Output stage
	// ------------------------------------------------------------
	logic [7:0] addr_reg_q;
	logic [7:0] drive_q;
	logic direct, power_on;
	assign direct = ~str_s.cs_n & ~str_s.wr_n & ~str_s.ale & str_s.rd_n &
		str_s.latch_n & off_n_s & cfg_done_o & ~cfg_q.serial_sel;
	assign power_on = ~rlev_s;

	// Address register presets to write access
	// Only write access exists here, so the top bit never changes after reset
	always_ff @(posedge clk_i) begin
		if (irst) begin
			addr_reg_q <= ADDR_REG_RST;
		end else begin
			addr_reg_q <= addr_reg_q;
		end
	end

	// Drive latch; output-off clears it
	always_ff @(posedge clk_i) begin
		if (irst || !off_n_s || !power_on) begin
			drive_q <= 8'h00;
		end else if (direct && addr_reg_q[7]) begin
			drive_q <= bus_s;
		end
	end

	// Overcurrent forces each channel off only while present; the latch keeps
	// its value, so the channel comes back without a new write
	always_ff @(posedge clk_i) begin
		if (irst) begin
			drive_outputs_o <= 8'h00;
		end else begin
			drive_outputs_o <= drive_q & ~ovc_s;
		end
	end

	// Power side status follows the reset-level comparator
	always_ff @(posedge clk_i) begin
		if (irst) begin
			power_on_o <= 1'b0;
		end else begin
			power_on_o <= power_on;
		end
	end

	// Bus lines never driven here: reads happen over the Wishbone slave
	always_ff @(posedge clk_i) begin
		if (irst) begin
			bus_lines_o <= 8'h00;
			bus_lines_oe_o <= 8'h00;
		end else begin
			bus_lines_o <= 8'h00;
			bus_lines_oe_o <= 8'h00;
		end
	end
endmodule
`default_nettype wire

/* test/smfs_top_props.sv */
// Checker for start-up, fault pin, supply and bus handshake of smfs_top
`default_nettype none
module smfs_top_props
	import smfs_pkg::*;
(
	// Clock, reset and bus handshake
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	// Supply and channel inputs
	input wire logic reset_level_i,
	input wire logic [7:0] overcurrent_i,
	// Observed outputs
	input wire logic [7:0] bus_lines_oe_o,
	input wire logic [7:0] drive_outputs_o,
	input wire logic power_on_o,
	input wire logic fault_n_o,
	input wire smfs_cfg_t cfg_o,
	input wire logic cfg_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// One domain, so clock and disable are given once
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_pre; $fell(rst_i) |-> !fault_n_o; endproperty
	a_pre: assert property (p_pre) else $error("fault pin high after reset");
	property p_hiz; !cfg_done_o |-> bus_lines_oe_o == 8'h00; endproperty
	a_hiz: assert property (p_hiz) else $error("bus driven before config");
	property p_done; $fell(rst_i) |-> ##[1:6] cfg_done_o; endproperty
	a_done: assert property (p_done) else $error("config never done");
	property p_hold; cfg_done_o && $past(cfg_done_o) |-> $stable(cfg_o); endproperty
	a_hold: assert property (p_hold) else $error("config changed in run");
	property p_rise; $rose(fault_n_o) |-> wb_ack_o || $past(wb_ack_o); endproperty
	a_rise: assert property (p_rise) else $error("fault released without read");
	property p_pwr; reset_level_i [*4] |-> !power_on_o; endproperty
	a_pwr: assert property (p_pwr) else $error("power side still on");
	property p_ovc; (overcurrent_i == 8'hff) [*5] |-> drive_outputs_o == 8'h00; endproperty
	a_ovc: assert property (p_ovc) else $error("channel on in overcurrent");
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus not answered");
	property p_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_one: assert property (p_one) else $error("ack longer than one cycle");
	// Main scenarios seen
	c_err: cover property (wb_err_o);
	c_free: cover property ($rose(fault_n_o));
	c_pwr: cover property ($fell(power_on_o));
endmodule
bind smfs_top smfs_top_props u_smfs_top_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.reset_level_i(reset_level_i), .overcurrent_i(overcurrent_i),
	.bus_lines_oe_o(bus_lines_oe_o), .drive_outputs_o(drive_outputs_o),
	.power_on_o(power_on_o), .fault_n_o(fault_n_o), .cfg_o(cfg_o), .cfg_done_o(cfg_done_o));
`default_nettype wire

/* test/smfs_mcu.sv */
// Controller model wired for the parallel direct mode
`default_nettype none
module smfs_mcu
	import smfs_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Bench control
	input wire logic direct_i,
	input wire logic [7:0] data_i,
	// Pins toward the device
	output smfs_strobe_t strobe_o,
	output logic outputs_off_n_o,
	output logic [7:0] bus_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// direct strobes
	// Released lines show the inverse of the data so a stale value never looks driven
	always_ff @(posedge clk_i) begin
		strobe_o <= direct_i ? 5'h05 : 5'h1d;
		outputs_off_n_o <= 1'h1;
		bus_o <= direct_i ? data_i : ~data_i;
	end
endmodule
`default_nettype wire

/* test/tb_smfs_top.sv */
// Self-checking bench for the supply monitor and start-up block
`default_nettype none
module tb_smfs_top
	import smfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Short blanking keeps the run brief
	localparam int unsigned BL = 20;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, err_q, ack, err;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0, dout, rd_q;
	logic lock = 1'h0, uv = 1'h0, miss = 1'h0, lvl = 1'h0, sel = 1'h0, direct = 1'h0;
	logic [1:0] fmt = 2'h2;
	logic link = 1'h0;
	logic [7:0] data = 8'h00, ovc = 8'h00, bus_w, oe_w, dev_bus, mcu_bus, outs;
	logic pwr, fault_n, irq, done, outputs_off_n_n;
	smfs_strobe_t strobe;
	smfs_cfg_t cfg;
	int fail_count = 0, samples_checked = 0, cyc_n = 0;
	always #4 clk_i = ~clk_i;
	// Wire level: whoever enables wins
	assign bus_w = (oe_w & dev_bus) | (~oe_w & mcu_bus);
	smfs_top #(.BLANK(BL)) u_smfs_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(dout), .wb_ack_o(ack), .wb_err_o(err), .supply_lockout_i(lock),
		.uv_cmp_i(uv), .miss_cmp_i(miss), .reset_level_i(lvl), .link_fault_i(link),
		.sel_pin_i(sel), .spi_format_pin0_i(fmt[0]), .spi_format_pin1_i(fmt[1]),
		.strobe_i(strobe), .outputs_off_n_i(outputs_off_n_n), .bus_lines_i(bus_w),
		.bus_lines_o(dev_bus), .bus_lines_oe_o(oe_w), .overcurrent_i(ovc),
		.drive_outputs_o(outs), .power_on_o(pwr), .fault_n_o(fault_n), .irq_o(irq),
		.cfg_o(cfg), .cfg_done_o(done));
	smfs_mcu u_smfs_mcu (.clk_i(clk_i), .direct_i(direct), .data_i(data),
		.strobe_o(strobe), .outputs_off_n_o(outputs_off_n_n), .bus_o(mcu_bus));
	task automatic give_verdict;
		if (fail_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Classic cycle: hold until ack or err is seen at an edge
	// Only the bench hang guard ends a wait that never sees an answer
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'h1 && err !== 1'h1);
		rd_q = dout;
		err_q = err;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		wb(1'h0, a, 32'h0);
		chk(rd_q, exp);
	endtask
	task automatic t_start;
		chk(32'(fault_n), 32'h0);
		chk(32'(outs), 32'h0);
		chk(32'(oe_w), 32'h0);
		chk(32'(dev_bus), 32'h0);
		tick(8);
		chk(32'(done), 32'h1);
		chk(32'(cfg), 32'h2);
		sel <= 1'h1;
		fmt <= 2'h1;
		tick(6);
		chk(32'(cfg), 32'h2);
	endtask
	task automatic t_regs;
		rd(OFS_MASK, 32'h0);
		wb(1'h1, OFS_MASK, 32'h2);
		rd(OFS_MASK, 32'h2);
		tick(2);
		chk(32'(irq), 32'h1);
		wb(1'h0, 4'h2, 32'h0);
		chk(32'(err_q), 32'h1);
		rd(OFS_GLOBAL, 32'h7);
		chk(32'(fault_n), 32'h0);
		rd(OFS_INTERNAL, 32'h0);
		tick(2);
		chk(32'(fault_n), 32'h1);
		chk(32'(irq), 32'h0);
	endtask
	task automatic t_lock;
		lock <= 1'h1;
		tick(6);
		chk(32'(fault_n), 32'h0);
		chk(32'(done), 32'h0);
		lock <= 1'h0;
		tick(10);
		chk(32'(cfg), 32'h5);
	endtask
	task automatic t_supply;
		rd(OFS_GLOBAL, 32'h7);
		rd(OFS_INTERNAL, 32'h0);
		uv <= 1'h1;
		miss <= 1'h1;
		tick(BL / 2);
		chk(32'(fault_n), 32'h1);
		tick(BL);
		chk(32'(fault_n), 32'h0);
		rd(OFS_GLOBAL, 32'h6);
		rd(OFS_INTERNAL, 32'h0);
		uv <= 1'h0;
		miss <= 1'h0;
		tick(BL + 8);
		rd(OFS_GLOBAL, 32'h6);
		rd(OFS_INTERNAL, 32'h0);
		chk(32'(fault_n), 32'h1);
		link <= 1'h1;
		tick(4);
		link <= 1'h0;
		chk(32'(fault_n), 32'h0);
		rd(OFS_GLOBAL, 32'h1);
		rd(OFS_INTERNAL, 32'h0);
		chk(32'(fault_n), 32'h1);
		lvl <= 1'h1;
		tick(6);
		chk(32'(pwr), 32'h0);
		rd(OFS_CONFIG, 32'h1d);
		lvl <= 1'h0;
	endtask
	task automatic t_direct;
		rst_i <= 1'h1;
		sel <= 1'h0;
		fmt <= 2'h2;
		direct <= 1'h1;
		data <= 8'ha5;
		tick(4);
		rst_i <= 1'h0;
		tick(10);
		chk(32'(outs), 32'ha5);
		ovc <= 8'h0f;
		tick(6);
		chk(32'(outs), 32'ha0);
		ovc <= 8'hff;
		tick(7);
		chk(32'(outs), 32'h00);
		ovc <= 8'h00;
		data <= 8'h5a;
		tick(6);
		chk(32'(outs), 32'h5a);
	endtask
	// Hang guard, well above the sum of all waits
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			fail_count++;
			$display("Error %0t: timeout", $time);
			give_verdict;
		end
	end
	initial begin
		tick(4);
		rst_i <= 1'h0;
		tick(1);
		t_start;
		t_regs;
		t_lock;
		t_supply;
		t_direct;
		give_verdict;
	end
endmodule
`default_nettype wire
